/* File: bench/sspi_far_dev.sv */
// Purpose: far spi slave that answers the port while the port is master
// Assumes: set to the same idle level and output edge as the port
// Notes:   reacts to the serial clock at once, as a real slave would; no own clock
`timescale 1ns/10ps
module sspi_far_dev (
  input  wire logic       sck_in,
  input  wire logic       ckp_in,
  input  wire logic       cke_in,
  input  wire logic       mosi_in,
  input  wire logic       load_in,
  input  wire logic [7:0] tx_in,
  output      logic       miso_out,
  output      logic [7:0] rx_out
);
  logic [7:0] sh_reg;
  always @(posedge load_in) begin
    sh_reg = tx_in;
    // with a late output edge the first bit must already stand before any clock edge
    miso_out = cke_in ? tx_in[7] : ~tx_in[7];
  end
  always @(sck_in) begin
    if (sck_in != ckp_in) begin
      if (cke_in) begin
        rx_out = {rx_out[6:0], mosi_in};
      end else begin
        miso_out = sh_reg[7];
        sh_reg = {sh_reg[6:0], 1'b0};
      end
    end else begin
      if (cke_in) begin
        sh_reg = {sh_reg[6:0], 1'b0};
        miso_out = sh_reg[7];
      end else begin
        rx_out = {rx_out[6:0], mosi_in};
      end
    end
  end
endmodule

/* File: bench/testbench.sv */
// Purpose: self-checking bench for the serial port, master and slave roles
// Assumes: far slave model in master role, bench acts as far master in slave role
// Notes:   fastest rate gets no receive compare, the input synchroniser may eat a half period there
`timescale 1ns/10ps
module testbench;
  import sspi_pkg::*;
  logic        core_clk, rst_b, wr, rd, tick, sck_drv, sdi_drv, sel_b, slv, far_load, far_ckp, far_cke;
  logic [1:0]  addr;
  logic [7:0]  wdata, rdata, far_tx, far_rx, v;
  logic        sck_out, sck_oe_b, sdo, sdo_oe_b, irq, miso;
  logic [2:0]  tcnt;
  int          n_mismatch, n_checks, cyc;
  wire         sdi = slv ? sdi_drv : miso;

  sspi_core sspi_core_i (.core_clk_in(core_clk), .rst_b_in(rst_b), .addr_in(addr), .wr_data_in(wdata),
    .wr_strobe_in(wr), .rd_strobe_in(rd), .rd_data_out(rdata), .timer_tick_in(tick), .sck_in(sck_drv),
    .sck_out(sck_out), .sck_oe_b_out(sck_oe_b), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_b_out(sdo_oe_b),
    .slave_sel_b_in(sel_b), .irq_flag_set_out(irq));
  sspi_far_dev sspi_far_dev_i (.sck_in(sck_out), .ckp_in(far_ckp), .cke_in(far_cke), .mosi_in(sdo),
    .load_in(far_load), .tx_in(far_tx), .miso_out(miso), .rx_out(far_rx));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // timer pulse every fifth cycle for the timer-driven rate
  always @(posedge core_clk) begin
    tcnt <= (tcnt == 3'h4) ? 3'h0 : tcnt + 3'h1;
    tick <= (tcnt == 3'h4);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // master frame; h is the half period in core cycles, 0 when not fixed
  task automatic mframe(input logic [7:0] d, input int h, input logic dup);
    int n;
    n = 0;
    repeat (3) @(posedge core_clk);
    chk("sck_idle", sck_out, far_ckp);
    far_load <= 1'b1;
    wr_reg(BUFFER_ADDR, d);
    if (dup) wr_reg(BUFFER_ADDR, 8'hFF);
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge core_clk);
      #1 n++;
    end
    far_load <= 1'b0;
    if (h > 0 && !dup) chk("frame_len", n[15:0], 16'(17 * h + 1));
    chk("far_rx", far_rx, d);
    chk("oe_pins", {sck_oe_b, sdo_oe_b}, 2'h0);
    repeat (4) @(posedge core_clk);
  endtask
  task automatic sframe(input logic [7:0] mo, output logic [7:0] got);
    for (int i = 7; i >= 0; i--) begin
      sdi_drv <= mo[i];
      repeat (8) @(posedge core_clk);
      got[i] = sdo;
      sck_drv <= 1'b1;
      repeat (8) @(posedge core_clk);
      sck_drv <= 1'b0;
    end
    sdi_drv <= ~mo[0];
    repeat (8) @(posedge core_clk);
  endtask

  initial begin
    logic [7:0] got;
    logic [3:0] m;
    {rst_b, wr, rd, tick, sck_drv, sdi_drv, slv, far_load, far_ckp, far_cke} = '0;
    {addr, wdata, far_tx, tcnt, n_mismatch, n_checks, cyc} = '0;
    sel_b = 1'b1;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd_reg(a[1:0]);
      chk("reset_val", v, 8'h00);
    end
    wr_reg(STATUS_ADDR, 8'hFF);
    rd_reg(STATUS_ADDR);
    chk("status_rw", v, 8'hC0);
    @(posedge core_clk);
    #1 chk("rd_idle", rdata, 8'h00);
    wr_reg(2'h3, 8'hFF);
    rd_reg(2'h3);
    chk("unmapped", v, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      m = k[3:0];
      far_ckp = m[0];
      far_cke = m[1];
      far_tx = 8'hC3 ^ {4'h0, m};
      wr_reg(STATUS_ADDR, {m[0], m[1], 6'h00});
      wr_reg(CONTROL_ADDR, {3'b001, m[0], m});
      mframe(8'h3C + {4'h0, m}, (m == 4'h0) ? 2 : (m == 4'h1) ? 8 : (m == 4'h2) ? 32 : 0, 1'b0);
      rd_reg(STATUS_ADDR);
      chk("bf_set", v, {m[0], m[1], 6'h01});
      rd_reg(BUFFER_ADDR);
      if (m != 4'h0) chk("rx_word", v, far_tx);
      rd_reg(STATUS_ADDR);
      chk("bf_clear", v[0], 1'b0);
    end
    $display("test master modes done");
    far_ckp = 1'b0;
    far_cke = 1'b1;
    far_tx = 8'h81;
    wr_reg(STATUS_ADDR, 8'h40);
    wr_reg(CONTROL_ADDR, 8'h21);
    mframe(8'h6E, 8, 1'b1);
    rd_reg(CONTROL_ADDR);
    chk("write_collision_set", v, 8'hA1);
    rd_reg(BUFFER_ADDR);
    chk("rx_after_write_collision", v, 8'h81);
    wr_reg(CONTROL_ADDR, 8'h21);
    rd_reg(CONTROL_ADDR);
    chk("write_collision_clear", v, 8'h21);
    wr_reg(CONTROL_ADDR, 8'h26);
    repeat (3) @(posedge core_clk);
    chk("reserved_pins", {sck_oe_b, sdo_oe_b}, 2'h3);
    $display("test collision and reserved done");
    slv = 1'b1;
    wr_reg(CONTROL_ADDR, 8'h24);
    repeat (4) @(posedge core_clk);
    chk("desel_pins", {sck_oe_b, sdo_oe_b}, 2'h3);
    repeat (3) begin
      repeat (8) @(posedge core_clk);
      sck_drv <= ~sck_drv;
    end
    repeat (8) @(posedge core_clk);
    sck_drv <= 1'b0;
    wr_reg(BUFFER_ADDR, 8'h5A);
    sel_b <= 1'b0;
    sframe(8'h96, got);
    chk("slave_tx", got, 8'h5A);
    rd_reg(STATUS_ADDR);
    chk("slave_bf", v, 8'h41);
    sframe(8'h33, got);
    rd_reg(CONTROL_ADDR);
    chk("ovf_set", v, 8'h64);
    rd_reg(BUFFER_ADDR);
    chk("ovf_keep", v, 8'h96);
    wr_reg(CONTROL_ADDR, 8'h25);
    sel_b <= 1'b1;
    wr_reg(BUFFER_ADDR, 8'hC6);
    sframe(8'hA5, got);
    chk("nosel_tx", got, 8'hC6);
    chk("nosel_oe", sdo_oe_b, 1'b0);
    rd_reg(BUFFER_ADDR);
    chk("nosel_rx", v, 8'hA5);
    $display("test slave done");
    close_out();
  end
endmodule

/* File: hdl/sspi_core.sv */
// Purpose: synchronous serial port in spi mode, master or slave, 8-bit full duplex
// Assumes: register port on core_clk_in; serial pins asynchronous and synchronised here
// Notes:   slave clock is oversampled, so the far master must run well below a quarter of core_clk
`timescale 1ns/10ps

// What this block does
// R1 - each transfer shifts eight bits out and eight bits in together
// R2 - all four combinations of clock idle level and output edge work
// R3 - three lines for data and clock; slave select only in slave role
// R4 - a complete word goes to the buffer and pulses the interrupt flag
// R5 - buffer write loads both buffer and shift register, no transmit double buffer
// R6 - shift register has no software path except through the buffer
// R7 - status: upper two bits read and write, lower six read only, reset zero
// R8 - master samples input at middle or end of bit time per sample bit
// R9 - software keeps the sample bit clear in slave role
// R10 - output edge bit picks active-to-idle or idle-to-active output change
// R11 - buffer full reads one after a received word lands, else zero
// R12 - stop bit is zero and cleared while the port is disabled
// R13 - status bits five to one have no spi use and are read only
// R14 - clock polarity bit defines idle and active clock levels
// R15 - control bits act only for spi modes; other modes leave pins idle
// R16 - mode field selects master rate divide 4, 16, 64, timer half, or slave
// R17 - buffer write during a transfer is dropped and sets sticky collision flag
// R18 - most significant bit first; buffer read clears buffer full
// R19 - slave word arriving while buffer full sets overflow and is lost
// R20 - deselected slave ignores clock edges and leaves its output undriven
module sspi_core
  import sspi_pkg::*;
(
  input  wire logic                          core_clk_in,
  input  wire logic                          rst_b_in,
  input  wire logic [sspi_pkg::ADDR_W-1:0]   addr_in,
  input  wire logic [sspi_pkg::DATA_W-1:0]   wr_data_in,
  input  wire logic                          wr_strobe_in,
  input  wire logic                          rd_strobe_in,
  output      logic [sspi_pkg::DATA_W-1:0]   rd_data_out,
  input  wire logic                          timer_tick_in,
  input  wire logic                          sck_in,
  output      logic                          sck_out,
  output      logic                          sck_oe_b_out,
  input  wire logic                          sdi_in,
  output      logic                          sdo_out,
  output      logic                          sdo_oe_b_out,
  input  wire logic                          slave_sel_b_in,
  output      logic                          irq_flag_set_out
);
  import sspi_pkg::*;

  sspi_rate_if rate ();

  logic                input_sample_late_reg;
  logic                tx_edge_reg;
  logic                receive_buffer_full_reg;
  logic                write_collision_reg;
  logic                receive_overflow_reg;
  logic                serial_port_enable_reg;
  logic                clock_idle_high_reg;
  logic [3:0]          port_mode_select_reg;
  logic [DATA_W-1:0]   serial_buffer_reg;
  logic [DATA_W-1:0]   serial_shift_reg;
  logic                sdo_reg;
  logic                sck_reg;
  logic                sck_oe_b_reg;
  logic                sdo_oe_b_reg;
  sspi_state_t         state_reg;
  logic [4:0]          half_reg;
  logic [3:0]          bcnt_reg;
  logic [DATA_W-1:0]   rd_data_reg;
  logic                irq_reg;
  logic                sck_s1_reg;
  logic                sck_s2_reg;
  logic                sck_s3_reg;
  logic                sdi_s1_reg;
  logic                sdi_s2_reg;
  logic                ss_s1_reg;
  logic                ss_s2_reg;

  sspi_role_t          role;
  logic                is_master;
  logic                is_slave;
  logic                ss_used;
  logic                ss_active;
  logic                wr_buf;
  logic                rd_buf;
  logic                wr_ctl;
  logic                wr_stat;
  logic                busy;
  logic                load;
  logic                m_tick;
  logic                m_sample;
  logic                m_out;
  logic                m_done;
  logic                s_edge;
  logic                s_lead;
  logic                sample;
  logic                shift_out;
  logic                word_done;
  logic                accept;
  logic                ovf_evt;
  logic [DATA_W-1:0]   shifted;
  logic [DATA_W-1:0]   done_word;

  sspi_rate_gen u_rate (
    .core_clk_in   (core_clk_in),
    .rst_b_in      (rst_b_in),
    .timer_tick_in (timer_tick_in),
    .rate          (rate.gen)
  );

  assign rate.mode = port_mode_select_reg;
  assign rate.run  = (state_reg == SSPI_SHIFT);

  // pins come from the far party's clock; first stage feeds only the second
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
      sck_s3_reg <= 1'b0;
      sdi_s1_reg <= 1'b0;
      sdi_s2_reg <= 1'b0;
      ss_s1_reg  <= 1'b1;
      ss_s2_reg  <= 1'b1;
    end else begin
      sck_s1_reg <= sck_in;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
      sdi_s1_reg <= sdi_in;
      sdi_s2_reg <= sdi_s1_reg;
      ss_s1_reg  <= slave_sel_b_in;
      ss_s2_reg  <= ss_s1_reg;
    end
  end

  always_comb begin
    role      = sspi_role(serial_port_enable_reg, port_mode_select_reg); // R15 R16
    is_master = (role == SSPI_ROLE_MASTER);
    is_slave  = (role == SSPI_ROLE_SLAVE);
    ss_used   = (port_mode_select_reg == MODE_S_SEL); // R3
    ss_active = !ss_used || !ss_s2_reg;
    wr_buf    = wr_strobe_in && addr_in == BUFFER_ADDR;
    rd_buf    = rd_strobe_in && addr_in == BUFFER_ADDR;
    wr_ctl    = wr_strobe_in && addr_in == CONTROL_ADDR;
    wr_stat   = wr_strobe_in && addr_in == STATUS_ADDR;
    busy      = is_master ? (state_reg == SSPI_SHIFT) : (bcnt_reg != 4'h0);
    load      = wr_buf && !busy; // R5
    // master half periods: even index leaves idle level, odd index returns to it
    m_tick    = rate.tick && state_reg == SSPI_SHIFT;
    m_sample  = m_tick && (half_reg[0] == (~tx_edge_reg ^ input_sample_late_reg)) // R8
                && !(input_sample_late_reg && half_reg == 5'h00) && bcnt_reg < BITS_FULL;
    m_out     = m_tick && half_reg[0] == tx_edge_reg && half_reg != LAST_HALF; // R10
    m_done    = m_tick && half_reg == LAST_HALF;
    s_edge    = is_slave && ss_active && (sck_s2_reg ^ sck_s3_reg); // R20
    s_lead    = (sck_s2_reg != clock_idle_high_reg); // R14
    sample    = is_master ? m_sample : (s_edge && s_lead == tx_edge_reg); // R2
    shift_out = is_master ? m_out : (s_edge && s_lead != tx_edge_reg); // R10
    shifted   = {serial_shift_reg[DATA_W-2:0], sdi_s2_reg}; // R18
    done_word = sample ? shifted : serial_shift_reg;
    word_done = is_master ? m_done : (sample && bcnt_reg == BITS_FULL - 4'h1); // R1
    accept    = word_done && (is_master || !receive_buffer_full_reg || rd_buf); // R4
    ovf_evt   = word_done && is_slave && receive_buffer_full_reg && !rd_buf; // R19
  end

  // sticky flags: hardware set beats a software clear in the same cycle
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      write_collision_reg    <= CONTROL_RESET[CTL_WRITE_COLLISION];
      receive_overflow_reg   <= CONTROL_RESET[CTL_OVF];
      serial_port_enable_reg <= CONTROL_RESET[CTL_EN];
      clock_idle_high_reg    <= CONTROL_RESET[CTL_CKP];
      port_mode_select_reg   <= CONTROL_RESET[3:0];
    end else begin
      if (wr_buf && busy) begin
        write_collision_reg <= 1'b1; // R17
      end else if (wr_ctl) begin
        write_collision_reg <= wr_data_in[CTL_WRITE_COLLISION];
      end
      if (ovf_evt) begin
        receive_overflow_reg <= 1'b1; // R19
      end else if (wr_ctl) begin
        receive_overflow_reg <= wr_data_in[CTL_OVF];
      end
      if (wr_ctl) begin
        serial_port_enable_reg <= wr_data_in[CTL_EN];
        clock_idle_high_reg    <= wr_data_in[CTL_CKP]; // R14
        port_mode_select_reg   <= wr_data_in[3:0]; // R16
      end
    end
  end

  // only the two upper status bits take writes
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      input_sample_late_reg <= STATUS_RESET[STAT_SMP];
      tx_edge_reg           <= STATUS_RESET[STAT_CKE];
    end else if (wr_stat) begin
      input_sample_late_reg <= wr_data_in[STAT_SMP]; // R7 R9
      tx_edge_reg           <= wr_data_in[STAT_CKE]; // R7
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      serial_buffer_reg       <= BUFFER_RESET;
      receive_buffer_full_reg <= STATUS_RESET[STAT_BF];
    end else begin
      if (accept) begin
        serial_buffer_reg       <= done_word; // R4
        receive_buffer_full_reg <= 1'b1; // R11
      end else begin
        if (load) begin
          serial_buffer_reg <= wr_data_in; // R5
        end
        if (rd_buf) begin
          receive_buffer_full_reg <= 1'b0; // R18
        end
      end
    end
  end

  // shift register is reachable only by a buffer write and the serial pins
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      serial_shift_reg <= BUFFER_RESET;
      sdo_reg          <= 1'b0;
      bcnt_reg         <= 4'h0;
    end else if (role == SSPI_ROLE_OFF || (ss_used && ss_s2_reg && is_slave)) begin
      bcnt_reg <= 4'h0; // R20
      if (load) begin
        serial_shift_reg <= wr_data_in; // R6
        if (tx_edge_reg) begin
          // late output edge: first bit must already stand when select drops
          sdo_reg <= wr_data_in[DATA_W-1]; // R10
        end
      end
    end else if (load) begin
      serial_shift_reg <= wr_data_in; // R5 R6
      bcnt_reg         <= 4'h0;
      if (tx_edge_reg) begin
        sdo_reg <= wr_data_in[DATA_W-1]; // R10
      end
    end else begin
      if (sample) begin
        serial_shift_reg <= shifted; // R1 R18
        bcnt_reg         <= (is_slave && bcnt_reg == BITS_FULL - 4'h1) ? 4'h0 : bcnt_reg + 4'h1;
      end
      if (shift_out) begin
        sdo_reg <= sample ? serial_shift_reg[DATA_W-2] : serial_shift_reg[DATA_W-1]; // R1 R10
      end
    end
  end

  // master frame: sixteen clock half periods plus one closing tick
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= SSPI_IDLE;
      half_reg  <= 5'h00;
      sck_reg   <= 1'b0;
    end else begin
      case (state_reg)
        SSPI_IDLE: begin
          sck_reg  <= clock_idle_high_reg; // R14
          half_reg <= 5'h00;
          if (load && is_master) begin
            state_reg <= SSPI_SHIFT;
          end
        end
        SSPI_SHIFT: begin
          if (!is_master) begin
            state_reg <= SSPI_IDLE; // R15
          end else if (m_done) begin
            state_reg <= SSPI_IDLE;
          end else if (m_tick) begin
            sck_reg  <= ~sck_reg; // R2
            half_reg <= half_reg + 5'h01;
          end
        end
        default: begin
          state_reg <= SSPI_IDLE;
        end
      endcase
    end
  end

  // drivers: low enable drives; slave never drives the clock line
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sck_oe_b_reg <= 1'b1;
      sdo_oe_b_reg <= 1'b1;
    end else begin
      sck_oe_b_reg <= !is_master; // R3
      sdo_oe_b_reg <= !(is_master || (is_slave && ss_active)); // R3 R20
    end
  end

  // read data stand for the one cycle after the strobe; stop bit and i2c bits stay zero
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_data_reg <= 8'h00;
      irq_reg     <= 1'b0;
    end else begin
      irq_reg <= accept; // R4
      if (!rd_strobe_in) begin
        rd_data_reg <= 8'h00;
      end else if (addr_in == STATUS_ADDR) begin
        rd_data_reg <= {input_sample_late_reg, tx_edge_reg, 5'h00, receive_buffer_full_reg}; // R7 R11 R12 R13
      end else if (addr_in == CONTROL_ADDR) begin
        rd_data_reg <= {write_collision_reg, receive_overflow_reg, serial_port_enable_reg,
                        clock_idle_high_reg, port_mode_select_reg};
      end else if (addr_in == BUFFER_ADDR) begin
        rd_data_reg <= serial_buffer_reg; // R6
      end else begin
        rd_data_reg <= 8'h00;
      end
    end
  end

  assign rd_data_out      = rd_data_reg;
  assign sck_out          = sck_reg;
  assign sck_oe_b_out     = sck_oe_b_reg;
  assign sdo_out          = sdo_reg;
  assign sdo_oe_b_out     = sdo_oe_b_reg;
  assign irq_flag_set_out = irq_reg;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  word_lands_a: assert property (accept |=> receive_buffer_full_reg && irq_reg
                                 && serial_buffer_reg == $past(done_word)) // R4
    else $error("received word not placed in buffer");
  buf_load_a: assert property (load && is_master |=> state_reg == SSPI_SHIFT
                               && serial_buffer_reg == $past(wr_data_in)) // R5
    else $error("buffer write did not start transfer");
  collision_a: assert property (wr_buf && busy && !accept |=> write_collision_reg
                                && $stable(serial_buffer_reg)) // R17
    else $error("colliding write not flagged or not ignored");
  bf_clear_a: assert property (rd_buf && !accept |=> !receive_buffer_full_reg) // R18
    else $error("buffer read did not clear full flag");
  overflow_a: assert property (ovf_evt |=> receive_overflow_reg && $stable(serial_buffer_reg)) // R19
    else $error("slave overflow mishandled");
  status_ro_a: assert property (rd_strobe_in && addr_in == STATUS_ADDR |=> rd_data_out[5:1] == 5'h00) // R13
    else $error("i2c status bits not zero");
  deselect_a: assert property (is_slave && ss_used && ss_s2_reg |=> sdo_oe_b_out) // R20
    else $error("deselected slave drives output");
  frame_bits_a: assert property (m_done |-> bcnt_reg == BITS_FULL
                                 || (sample && bcnt_reg == BITS_FULL - 4'h1)) // R1
    else $error("master frame not eight bits");
  out_edge_a: assert property (m_tick && half_reg[0] != tx_edge_reg && !load |=> $stable(sdo_reg)) // R10
    else $error("output changed on wrong clock edge");
  idle_level_a: assert property (state_reg == SSPI_IDLE && $past(state_reg) == SSPI_IDLE
                                 && $stable(clock_idle_high_reg) |-> sck_out == clock_idle_high_reg) // R14
    else $error("serial clock not at idle level");
  sample_mid_a: assert property (m_sample && !input_sample_late_reg
                                 |-> (sck_reg == clock_idle_high_reg) == tx_edge_reg) // R8
    else $error("master sample point wrong");

  master_word_c: cover property (is_master && accept);
  slave_word_c: cover property (is_slave && accept);
  overflow_c: cover property (ovf_evt);
  collision_c: cover property (wr_buf && busy);

endmodule

/* File: hdl/sspi_rate_gen.sv */
// Purpose: half-period enable for the master serial clock
// Assumes: timer_tick_in is a one-cycle pulse on the core clock
// Notes:   counter restarts whenever run drops, so every divider-rate frame starts with a full half period; timer mode follows timer_tick_in
`timescale 1ns/10ps
module sspi_rate_gen
  import sspi_pkg::*;
(
  input  wire logic   core_clk_in,
  input  wire logic   rst_b_in,
  input  wire logic   timer_tick_in,
  sspi_rate_if.gen    rate
);

  logic [5:0] cnt_reg;
  logic       tick_reg;
  logic [5:0] half_len;

  always_comb begin
    half_len = HALF_DIV4;
    if (rate.mode == MODE_M_DIV16) begin
      half_len = HALF_DIV16;
    end else if (rate.mode == MODE_M_DIV64) begin
      half_len = HALF_DIV64;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_reg  <= 6'h00;
      tick_reg <= 1'b0;
    end else if (!rate.run) begin
      cnt_reg  <= 6'h00;
      tick_reg <= 1'b0;
    end else if (rate.mode == MODE_M_TMR) begin
      tick_reg <= timer_tick_in; // R16
    end else if (cnt_reg == half_len - 6'h01) begin
      cnt_reg  <= 6'h00;
      tick_reg <= 1'b1; // R16
    end else begin
      cnt_reg  <= cnt_reg + 6'h01;
      tick_reg <= 1'b0;
    end
  end

  assign rate.tick = tick_reg;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  tick_single_a: assert property (tick_reg && rate.mode != MODE_M_TMR |=> !tick_reg) // R16
    else $error("rate tick longer than one cycle");
  div4_gap_a: assert property (rate.run && rate.mode == MODE_M_DIV4 && tick_reg ##1 rate.run [*2] |-> tick_reg) // R16
    else $error("divide by four half period wrong");

endmodule

/* File: pkg/sspi_pkg.sv */
// Purpose: shared constants and types for the synchronous serial port in spi mode
// Assumes: core clock is the port's reference clock; register map is a small local index map
// Notes:   register indices, field positions, reset values and divider counts live here only
package sspi_pkg;

  localparam int ADDR_W    = 2;
  localparam int DATA_W    = 8;
  localparam int WORD_BITS = 8;

  localparam logic [ADDR_W-1:0] STATUS_ADDR  = 2'h0;
  localparam logic [ADDR_W-1:0] CONTROL_ADDR = 2'h1;
  localparam logic [ADDR_W-1:0] BUFFER_ADDR  = 2'h2;

  localparam int STAT_SMP = 7;
  localparam int STAT_CKE = 6;
  localparam int STAT_BF  = 0;
  localparam int CTL_WRITE_COLLISION = 7;
  localparam int CTL_OVF  = 6;
  localparam int CTL_EN   = 5;
  localparam int CTL_CKP  = 4;

  localparam logic [DATA_W-1:0] STATUS_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] BUFFER_RESET  = 8'h00;

  localparam logic [3:0] MODE_M_DIV4  = 4'h0;
  localparam logic [3:0] MODE_M_DIV16 = 4'h1;
  localparam logic [3:0] MODE_M_DIV64 = 4'h2;
  localparam logic [3:0] MODE_M_TMR   = 4'h3;
  localparam logic [3:0] MODE_S_SEL   = 4'h4;
  localparam logic [3:0] MODE_S_NOSEL = 4'h5;

  // core clock cycles per half period of the serial clock, then the last half period index and the bits per word
  localparam logic [5:0] HALF_DIV4  = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;
  localparam logic [4:0] LAST_HALF  = 5'h10;
  localparam logic [3:0] BITS_FULL  = 4'h8;

  typedef enum logic [1:0] {SSPI_ROLE_OFF, SSPI_ROLE_MASTER, SSPI_ROLE_SLAVE} sspi_role_t;
  typedef enum logic {SSPI_IDLE, SSPI_SHIFT} sspi_state_t;

  function automatic sspi_role_t sspi_role(input logic en, input logic [3:0] mode);
    sspi_role_t r;
    r = SSPI_ROLE_OFF;
    if (en && mode <= MODE_M_TMR) begin
      r = SSPI_ROLE_MASTER;
    end else if (en && (mode == MODE_S_SEL || mode == MODE_S_NOSEL)) begin
      r = SSPI_ROLE_SLAVE;
    end
    return r;
  endfunction

endpackage

/* File: pkg/sspi_rate_if.sv */
// Purpose: carries the bit-rate selection and the half-period tick between core and divider
// Assumes: all signals on the core clock
// Notes:   tick is a one-cycle enable, never a clock
`timescale 1ns/10ps
interface sspi_rate_if;
  logic [3:0] mode;
  logic       run;
  logic       tick;
  modport core (output mode, output run, input tick);
  modport gen  (input mode, input run, output tick);
endinterface
